// ---- hdl/rmw_map.svh ----
// Function
// - Five hardware reset sources are accepted
// - Cold reset from power-on, and from the pin on the newer variant
// - System reset from cold or enabled sources
// - Port reset follows system when enabled
// - Combo, timeout, bad-address skip doze and cold
// - Pin on newer variant asserts all four
// - Power-on reset held five to twenty ms
// - Pin reset stretched per variant after release
// - Timeout reset needs enable and expiry
// - Timeout enable cleared only by cold reset
// - Bad address with enable causes reset
// - Doze request needs unlock, reads zero
// - Separate cause flags, none means power-on
// - Pin wake from doze sets both flags
// - Key 0x0a then 0x03 clears counter
// - Other watchdog write between keys abandons clear
// - Four-bit counter, reset at eight
// - Timeout at least two seconds
// - Counter runs on slow tick, stops without rc
// - Control register bit layout, cold cleared
// - Cause register bit layout
// - Watchdog register key write, count read
//
// Register offsets, field positions and timing counts of the reset manager.
// Assumes a 100 MHz reference clock and a byte-wide register port.
`ifndef RMW_MAP_SVH
`define RMW_MAP_SVH

`define RMW_ADDR_CAUSE      2'h0
`define RMW_ADDR_CTRL       2'h1
`define RMW_ADDR_WDOG       2'h2

`define RMW_CTRL_UNLOCK     7
`define RMW_CTRL_PORTEN     6
`define RMW_CTRL_BADEN      5
`define RMW_CTRL_WDEN       4

`define RMW_CAUSE_DOZE      7
`define RMW_CAUSE_BAD       5
`define RMW_CAUSE_WD        4
`define RMW_CAUSE_COMBO     3
`define RMW_CAUSE_PIN       2
`define RMW_CAUSE_PINDOZE   1

`define RMW_KEY_FIRST       4'ha
`define RMW_KEY_SECOND      4'h3
`define RMW_WD_LIMIT        4'h8

`define RMW_CLK_NS          10
`define RMW_POR_MIN_MS      5
`define RMW_PIN_OLD_MIN_US  20
`define RMW_PIN_NEW_MIN_MS  5
`define RMW_POR_CYCLES     ((`RMW_POR_MIN_MS * 1000000 + `RMW_CLK_NS - 1) / `RMW_CLK_NS)
`define RMW_PIN_OLD_CYCLES ((`RMW_PIN_OLD_MIN_US * 1000 + `RMW_CLK_NS - 1) / `RMW_CLK_NS)
`define RMW_PIN_NEW_CYCLES ((`RMW_PIN_NEW_MIN_MS * 1000000 + `RMW_CLK_NS - 1) / `RMW_CLK_NS)

`endif

// ---- hdl/rmw_pkg.sv ----
// Types shared by the reset manager.
// Assumes the constants come from rmw_map.svh.
package rmw_pkg;
  // Watchdog key sequence state
  typedef enum logic [0:0] {
    RMW_KEY_IDLE  = 1'b0,
    RMW_KEY_ARMED = 1'b1
  } rmw_key_t;
  typedef logic [7:0] rmw_byte_t;
endpackage : rmw_pkg

// ---- hdl/rmw_reset_manager.sv ----
// Reset manager with cause flags, doze request and key-serviced watchdog.
// Assumes one 100 MHz clock; pin and combo inputs are asynchronous, the
// power-on detector, bad-address and tick inputs are on ref_clk.
//
// Strobed register access and the register addresses were left to the implementer.
`include "rmw_map.svh"
`timescale 1ns/1ps
`default_nettype none
module rmw_reset_manager #(
  parameter int unsigned PorCycles    = `RMW_POR_CYCLES,
  parameter int unsigned PinOldCycles = `RMW_PIN_OLD_CYCLES,
  parameter int unsigned PinNewCycles = `RMW_PIN_NEW_CYCLES,
  parameter bit          NewVariant   = 1'b1
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Reset sources
  input  wire logic              powerOnDetect,
  input  wire logic              resetPin,
  input  wire logic              portComboReq,
  input  wire logic              badAddressError,
  // Watchdog clocking
  input  wire logic              lowPrescTick,
  input  wire logic              rcOscEnable,
  // Register port
  input  wire logic [1:0]        regAddr,
  input  wire rmw_pkg::rmw_byte_t regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output var  rmw_pkg::rmw_byte_t regRdata,
  // Internal resets
  output logic                   coldReset,
  output logic                   systemReset,
  output logic                   portSetupReset,
  output logic                   dozeReset
);
  import rmw_pkg::*;

  // All checks below sample on the reference clock and rest while the
  // block is held in its own reset
  default clocking cb_chk @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // Overview of the reset fan-out
  // - The power-on stretch drives the cold source; on the newer variant
  //   the stretched pin joins it, so the pin clears the control bits and watchdog state there.
  // - Warm sources (pin, port combination, enabled timeout, enabled bad
  //   address) raise the system reset and, when enabled, the port reset.
  // - The doze request only raises the doze reset and is left by the pin.
  // - Every internal reset is registered once, so outputs trail their
  //   sources by one clock; consumers see clean, glitch-free levels.
  // - Cause flags survive warm resets and clear only on power-on or on a
  //   software write, so the boot code can read why it restarted.
  // Limitation: the stretch counters are 32 bits wide to cover the
  // millisecond spans at the reference clock; a slower clock would let
  // them shrink, but the width is kept fixed for one build.

  // Synchronisers for asynchronous pins
  logic pinMeta_r, pinSync_r, comboMeta_r, comboSync_r;
  always_ff @(posedge ref_clk) begin
    pinMeta_r   <= resetPin;
    pinSync_r   <= pinMeta_r;
    comboMeta_r <= portComboReq;
    comboSync_r <= comboMeta_r;
  end

  // Power-on stretch: held from detection until the counter expires
  logic [31:0] porCnt_r;
  logic        porActive;
  assign porActive = powerOnDetect || (porCnt_r != 32'h0);
  always_ff @(posedge ref_clk) begin
    if (!reset_n || powerOnDetect) begin
      porCnt_r <= PorCycles;
    end else if (porCnt_r != 32'h0) begin
      porCnt_r <= porCnt_r - 32'h1;
    end
  end

  // Pin stretch: counter reloads while the pin is high
  logic [31:0] pinCnt_r;
  logic        pinActive;
  assign pinActive = pinSync_r || (pinCnt_r != 32'h0);
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pinCnt_r <= 32'h0;
    end else if (pinSync_r) begin
      // Stretch length depends on variant
      pinCnt_r <= NewVariant ? PinNewCycles : PinOldCycles;
    end else if (pinCnt_r != 32'h0) begin
      pinCnt_r <= pinCnt_r - 32'h1;
    end
  end

  // Cold domain: power-on, and the pin on the newer variant
  logic coldSrc;
  assign coldSrc = porActive || (NewVariant && pinActive);

  // Control register
  logic unlock_r, portEn_r, badEn_r, wdEn_r;
  logic wrCause, wrCtrl, wrWdog;
  assign wrCause = regWrite && (regAddr == `RMW_ADDR_CAUSE);
  assign wrCtrl  = regWrite && (regAddr == `RMW_ADDR_CTRL);
  assign wrWdog  = regWrite && (regAddr == `RMW_ADDR_WDOG);

  // Control bits clear on cold reset; timeout enable is sticky
  always_ff @(posedge ref_clk) begin
    if (!reset_n || coldSrc) begin
      unlock_r <= 1'b0;
      portEn_r <= 1'b0;
      badEn_r  <= 1'b0;
      wdEn_r   <= 1'b0;
    end else if (wrCtrl) begin
      unlock_r <= regWdata[`RMW_CTRL_UNLOCK];
      portEn_r <= regWdata[`RMW_CTRL_PORTEN];
      badEn_r  <= regWdata[`RMW_CTRL_BADEN];
      // Software may set but never clear
      wdEn_r   <= wdEn_r | regWdata[`RMW_CTRL_WDEN];
    end
  end

  // Watchdog counter and key sequence
  logic [3:0] wdCnt_r;
  rmw_key_t   keyState_r;
  logic       keyOk, armKey, wdExpired, wdTick;
  assign keyOk = wrWdog && (keyState_r == RMW_KEY_ARMED)
                 && (regWdata[3:0] == `RMW_KEY_SECOND);
  // First key seen on a watchdog write
  assign armKey = wrWdog && (regWdata[3:0] == `RMW_KEY_FIRST);
  assign wdExpired = (wdCnt_r == `RMW_WD_LIMIT);
  // Tick only counts while the RC source keeps the prescaler alive
  assign wdTick = lowPrescTick && rcOscEnable;

  // Key sequencer: any other watchdog write abandons the sequence, while
  // writes to the other registers leave it armed
  always_ff @(posedge ref_clk) begin
    if (!reset_n || coldSrc) begin
      keyState_r <= RMW_KEY_IDLE;
    end else if (wrWdog) begin
      case (keyState_r)
        // Only the first key arms the sequence
        RMW_KEY_IDLE: begin
          keyState_r <= armKey ? RMW_KEY_ARMED : RMW_KEY_IDLE;
        end
        // Second key or a foreign value returns to idle; a repeated
        // first key keeps the sequence armed
        RMW_KEY_ARMED: begin
          keyState_r <= armKey ? RMW_KEY_ARMED : RMW_KEY_IDLE;
        end
        default: begin
          keyState_r <= RMW_KEY_IDLE;
        end
      endcase
    end
  end

  // Counter saturates at eight so the timeout holds until serviced
  always_ff @(posedge ref_clk) begin
    if (!reset_n || coldSrc || keyOk) begin
      wdCnt_r <= 4'h0;
    end else if (wdTick && !wdExpired) begin
      wdCnt_r <= wdCnt_r + 4'h1;
    end
  end

  // Source qualification
  logic wdReset, badReset, comboReset, warmSrc;
  assign wdReset    = wdEn_r && wdExpired;
  assign badReset   = badEn_r && badAddressError;
  assign comboReset = comboSync_r;
  assign warmSrc    = wdReset || badReset || comboReset
                      || pinActive;

  // Doze request: self clearing, needs unlock
  logic dozeReq, doze_r, doze_nxt;
  assign dozeReq  = wrCause && regWdata[`RMW_CAUSE_DOZE] && unlock_r;
  assign doze_nxt = dozeReq ? 1'b1 : (pinActive ? 1'b0 : doze_r);
  always_ff @(posedge ref_clk) begin
    if (!reset_n || porActive) begin
      doze_r <= 1'b0;
    end else begin
      doze_r <= doze_nxt;
    end
  end

  // Cause flags: set wins over the clearing write
  logic [5:1] cause_r, causeSet;
  assign causeSet[5] = badReset;
  assign causeSet[4] = wdReset;
  assign causeSet[3] = comboReset;
  assign causeSet[2] = pinSync_r;
  assign causeSet[1] = pinSync_r && doze_r;
  // One flag per cause bit; a new event wins over the clearing write
  for (genvar gi = 1; gi <= 5; gi++) begin : g_cause
    logic flag_r;  // Sticky flag of this cause
    always_ff @(posedge ref_clk) begin
      if (!reset_n || porActive) begin
        flag_r <= 1'b0;
      end else if (causeSet[gi]) begin
        flag_r <= 1'b1;
      end else if (wrCause) begin
        flag_r <= 1'b0;
      end
    end
    assign cause_r[gi] = flag_r;
  end : g_cause

  // Read data one cycle after the strobe
  logic [7:0] rdMux;
  assign rdMux = (regAddr == `RMW_ADDR_CAUSE) ?
                   {2'b00, cause_r[5:2], cause_r[1], 1'b0} :
                 (regAddr == `RMW_ADDR_CTRL) ?
                   {unlock_r, portEn_r, badEn_r, wdEn_r, 4'h0} :
                 (regAddr == `RMW_ADDR_WDOG) ?
                   {4'h0, wdCnt_r} : 8'h00;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= regRead ? rdMux : 8'h00;
    end
  end

  // Internal resets
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      coldReset      <= 1'b1;
      systemReset    <= 1'b1;
      portSetupReset <= 1'b1;
      dozeReset      <= 1'b1;
    end else begin
      coldReset      <= coldSrc;
      systemReset    <= coldSrc || warmSrc;
      portSetupReset <= coldSrc || (portEn_r && warmSrc);
      dozeReset      <= coldSrc || doze_r;
    end
  end

  // Checks
  // Each property names the rule it guards on its label line; the named
  // sequences describe the multi-step watchdog key traffic.

  // First key on the watchdog register
  sequence s_key_first;
    wrWdog && (regWdata[3:0] == `RMW_KEY_FIRST);
  endsequence

  // Second key on the watchdog register
  sequence s_key_second;
    wrWdog && (regWdata[3:0] == `RMW_KEY_SECOND);
  endsequence

  // Any watchdog write that is neither key
  sequence s_key_other;
    wrWdog && (regWdata[3:0] != `RMW_KEY_FIRST)
    && (regWdata[3:0] != `RMW_KEY_SECOND);
  endsequence

  // Cold output never rises without a cold source
  a_cold_no_warm: assert property (
    !coldSrc |=> !coldReset)
    else $error("cold reset without power-on source");

  // Every warm source reaches the system reset
  a_sys_follows: assert property (
    warmSrc |=> systemReset)
    else $error("system reset missed warm source");

  // Port reset stays low for warm sources while disabled
  a_port_gated: assert property (
    (!coldSrc && !portEn_r && warmSrc) |=> !portSetupReset)
    else $error("port reset without enable");

  // Timeout enable survives everything but a cold source
  a_wd_sticky: assert property (
    (wdEn_r && !coldSrc) |=> wdEn_r)
    else $error("timeout enable dropped");

  // Valid key pair clears the counter
  a_key_clear: assert property (
    keyOk |=> (wdCnt_r == 4'h0))
    else $error("key did not clear counter");

  // Expired counter with enable raises the system reset
  a_wd_timeout: assert property (
    (wdEn_r && wdExpired && !coldSrc) |=> systemReset)
    else $error("timeout gave no reset");

  // Request bit has no effect while locked
  a_doze_locked: assert property (
    (wrCause && !unlock_r && !doze_r) |=> !doze_r)
    else $error("doze entered while locked");

  // Counter never passes the timeout value
  a_cnt_range: assert property (
    wdCnt_r <= `RMW_WD_LIMIT)
    else $error("watchdog count beyond eight");

  // Pin flag is kept until software writes the cause register
  a_flags_hold: assert property (
    (!wrCause && !porActive && cause_r[2]) |=> cause_r[2])
    else $error("cause flag lost without write");

  // Stretched power-on holds the cold reset
  a_por_cold: assert property (
    porActive |=> coldReset)
    else $error("power-on stretch without cold reset");

  // On the newer variant the pin raises all four resets
  a_pin_all: assert property (
    (NewVariant && pinSync_r)
    |=> (coldReset && systemReset && portSetupReset && dozeReset))
    else $error("pin did not raise every reset");

  // Warm sources leave the cold and doze resets alone
  a_warm_not_cold: assert property (
    (!coldSrc && !doze_r && warmSrc) |=> (!coldReset && !dozeReset))
    else $error("warm source reached cold or doze reset");

  // Doze alone raises only the doze reset
  a_doze_only: assert property (
    (doze_r && !coldSrc && !warmSrc)
    |=> (dozeReset && !systemReset && !portSetupReset && !coldReset))
    else $error("doze raised another reset");

  // Cold source clears the control bits
  a_ctrl_cleared: assert property (
    coldSrc |=> (!unlock_r && !portEn_r && !badEn_r && !wdEn_r))
    else $error("control bit kept through cold reset");

  // Expired counter holds until serviced
  a_wd_hold: assert property (
    (wdExpired && !keyOk && !coldSrc) |=> wdExpired)
    else $error("timeout dropped without key");

  // Stopped oscillator freezes the counter
  a_tick_stopped: assert property (
    (!rcOscEnable && !keyOk && !coldSrc) |=> $stable(wdCnt_r))
    else $error("counter moved with oscillator off");

  // A foreign watchdog write disarms a pending first key
  a_key_abandon: assert property (
    (s_key_first ##[1:4] s_key_other) |=> (keyState_r == RMW_KEY_IDLE))
    else $error("key sequence survived other write");

  // Second key after an abandoned sequence leaves the counter alone
  a_key_no_clear: assert property (
    (s_key_other ##1 !wrWdog ##1 s_key_second) |-> !keyOk)
    else $error("abandoned sequence cleared counter");

  // Pin seen by the block sets its cause flag
  a_pin_flag: assert property (
    (pinSync_r && !porActive) |=> cause_r[2])
    else $error("pin flag not set");

  // Pin during doze sets both pin flags
  a_pin_doze: assert property (
    (pinSync_r && doze_r && !porActive) |=> (cause_r[2] && cause_r[1]))
    else $error("pin wake flags not both set");

  // Read data stand only after a read strobe
  a_rd_idle: assert property (
    !regRead |=> (regRdata == 8'h00))
    else $error("read data without read strobe");

  // Unused cause bits and the request bit read zero
  a_cause_zero: assert property (
    (regRead && (regAddr == `RMW_ADDR_CAUSE))
    |=> ((regRdata[7:6] == 2'b00) && !regRdata[0]))
    else $error("cause register reserved bit set");

  // Upper watchdog bits read zero
  a_wd_upper: assert property (
    (regRead && (regAddr == `RMW_ADDR_WDOG)) |=> (regRdata[7:4] == 4'h0))
    else $error("watchdog upper bits set");
endmodule : rmw_reset_manager
`default_nettype wire

// ---- verification/rmw_cpu_model.sv ----
// Software side of the reset manager register port: byte reads and writes.
// Assumes one clock and a slave that never makes the master wait.
`timescale 1ns/1ps
`default_nettype none
module rmw_cpu_model (
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output logic [1:0]      regAddr,
  output logic [7:0]      regWdata,
  output logic            regWrite,
  output logic            regRead,
  input  wire logic [7:0] regRdata
);
  // Idle bus at time zero, parked on the unmapped slot
  initial begin
    regAddr  = 2'h3;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead  = 1'b0;
  end

  // One-cycle write; keys are sent as two such writes
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    regWdata <= ~d;  // Stale data is not left standing on the bus
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] q);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 q = regRdata;
  endtask : rd
endmodule : rmw_cpu_model
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the reset manager with shortened stretch counts.
// Assumes the software model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rmw_pkg::*;
  // Design inputs and outputs
  logic ref_clk = 1'b0, reset_n = 1'b0, pod = 1'b0, pin = 1'b0;
  logic combo = 1'b0, bad = 1'b0, tick = 1'b0, rcOn = 1'b1;
  logic [1:0] a;
  logic [7:0] wd, rdat, q;
  logic we, re, cold, sys, port, doze;
  logic coldOld, sysOld, portOld;
  int n_fail = 0, n_compared = 0, n;

  always #5 ref_clk = ~ref_clk;

  rmw_cpu_model i_rmw_cpu_model (.ref_clk(ref_clk), .regAddr(a),
    .regWdata(wd), .regWrite(we), .regRead(re), .regRdata(rdat));
  rmw_reset_manager #(.PorCycles(20), .PinOldCycles(20), .PinNewCycles(20),
    .NewVariant(1'b1)) i_rmw_reset_manager (.ref_clk(ref_clk),
    .reset_n(reset_n), .powerOnDetect(pod), .resetPin(pin),
    .portComboReq(combo), .badAddressError(bad), .lowPrescTick(tick),
    .rcOscEnable(rcOn), .regAddr(a), .regWdata(wd), .regWrite(we),
    .regRead(re), .regRdata(rdat), .coldReset(cold), .systemReset(sys),
    .portSetupReset(port), .dozeReset(doze));
  // Older variant beside it, for the pin fan-out only
  rmw_reset_manager #(.PorCycles(20), .PinOldCycles(20), .PinNewCycles(20),
    .NewVariant(1'b0)) i_rmw_reset_manager_old (.ref_clk(ref_clk),
    .reset_n(reset_n), .powerOnDetect(pod), .resetPin(pin),
    .portComboReq(combo), .badAddressError(bad), .lowPrescTick(tick),
    .rcOscEnable(rcOn), .regAddr(a), .regWdata(wd), .regWrite(we),
    .regRead(re), .regRdata(), .coldReset(coldOld), .systemReset(sysOld),
    .portSetupReset(portOld), .dozeReset());

  // Compare and count
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
    end
  endtask : chk
  // Read a register and compare
  task automatic rchk(input logic [1:0] ad, input logic [7:0] e);
    i_rmw_cpu_model.rd(ad, q);
    chk(q, e);
  endtask : rchk
  // Bounded wait for the system reset level; n counts the cycles taken
  task automatic wsys(input logic v);
    n = 0;
    #1;
    while (sys !== v && n < 100) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(sys, v);
  endtask : wsys
  // Prescaler ticks, one cycle each
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge ref_clk) tick <= 1'b1;
      @(posedge ref_clk) tick <= 1'b0;
    end
  endtask : ticks

  // Power-on stretch and register reset values
  task automatic t_por;
    #1 chk({cold, sys, port, doze}, 8'h0f);
    wsys(1'b0);
    chk(n >= 20, 1'b1);
    chk(cold, 1'b0);
    rchk(2'h0, 8'h00);
    rchk(2'h1, 8'h00);
    rchk(2'h2, 8'h00);
    rchk(2'h3, 8'h00);
    i_rmw_cpu_model.wr(2'h1, 8'hff);
    rchk(2'h1, 8'hf0);
    i_rmw_cpu_model.wr(2'h1, 8'h00);
    rchk(2'h1, 8'h10);
  endtask : t_por

  // Key sequence, abandon, stopped clock and timeout
  task automatic t_wdog;
    ticks(5);
    rchk(2'h2, 8'h05);
    i_rmw_cpu_model.wr(2'h2, 8'h0a);
    i_rmw_cpu_model.wr(2'h2, 8'h05);
    i_rmw_cpu_model.wr(2'h2, 8'h03);
    rchk(2'h2, 8'h05);
    @(posedge ref_clk) rcOn <= 1'b0;
    ticks(2);
    rcOn <= 1'b1;
    rchk(2'h2, 8'h05);
    i_rmw_cpu_model.wr(2'h2, 8'h0a);
    i_rmw_cpu_model.wr(2'h1, 8'h00);
    i_rmw_cpu_model.wr(2'h2, 8'h03);
    rchk(2'h2, 8'h00);
    ticks(7);
    #1 chk(sys, 1'b0);
    ticks(1);
    wsys(1'b1);
    chk({cold, port, doze}, 8'h00);
    rchk(2'h2, 8'h08);
    i_rmw_cpu_model.wr(2'h2, 8'h0a);
    i_rmw_cpu_model.wr(2'h2, 8'h03);
    wsys(1'b0);
    rchk(2'h0, 8'h10);
  endtask : t_wdog

  // Port combination and bad-address sources, flag accumulation
  task automatic t_src;
    i_rmw_cpu_model.wr(2'h0, 8'h00);
    @(posedge ref_clk) bad <= 1'b1;
    @(posedge ref_clk) bad <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 chk(sys, 1'b0);
    i_rmw_cpu_model.wr(2'h1, 8'h60);
    rchk(2'h1, 8'h70);
    @(posedge ref_clk) combo <= 1'b1;
    repeat (3) @(posedge ref_clk);
    combo <= 1'b0;
    wsys(1'b1);
    chk({cold, port, doze}, 8'h02);
    wsys(1'b0);
    @(posedge ref_clk) bad <= 1'b1;
    @(posedge ref_clk) bad <= 1'b0;
    wsys(1'b1);
    chk({cold, port, doze}, 8'h02);
    wsys(1'b0);
    rchk(2'h0, 8'h28);
    i_rmw_cpu_model.wr(2'h0, 8'h5a);
    rchk(2'h0, 8'h00);
  endtask : t_src

  // Locked and unlocked doze request, then pin wake on the newer variant
  task automatic t_doze;
    i_rmw_cpu_model.wr(2'h1, 8'h10);
    i_rmw_cpu_model.wr(2'h0, 8'h80);
    repeat (4) @(posedge ref_clk);
    #1 chk(doze, 1'b0);
    i_rmw_cpu_model.wr(2'h1, 8'h80);
    i_rmw_cpu_model.wr(2'h0, 8'h80);
    repeat (3) @(posedge ref_clk);
    #1 chk({cold, sys, port, doze}, 8'h01);
    rchk(2'h0, 8'h00);
    @(posedge ref_clk) pin <= 1'b1;
    wsys(1'b1);
    chk({cold, port, doze}, 8'h07);
    chk({coldOld, sysOld, portOld}, 8'h02);
    @(posedge ref_clk) pin <= 1'b0;
    #1 wsys(1'b0);
    chk(n >= 20, 1'b1);
    rchk(2'h0, 8'h06);
  endtask : t_doze

  // Verdict and end of run
  task automatic stop_test;
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Watchdog against a hang
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_por();
    t_wdog();
    t_src();
    t_doze();
    stop_test();
  end
endmodule : tb
`default_nettype wire
